/* File: rtl/sensor_status_interrupt_regs.sv */
// status and interrupt-control register bank behind a serial target port
`default_nettype none
`include "sensor_status_params.svh"
// Overview of operation
// - busy flag while power command processes
// - flag when rate setting overwritten early
// - flag when averaging setting overwritten early
// - bit3 shows periodic power mode active
// - flag when last command was rejected
// - readback of effective rate and averaging
// - reading error register clears it whole
// - writing one clears single error flag
// - parity error sets bit0 until cleared
// - S0/S1 error self-clears after 60us
// - watchdog enable bit, off at reset
// - watchdog timeout 1.28ms or 40.96ms
// - latched or pulsed interrupt output mode
// - interrupt polarity high or low
// - open-drain or push-pull interrupt drive
// - pin routing enable, ignored first revision
// - data-ready enable for status and pin
// - data-ready raises in-band interrupt if mapped
// - optional auto-clear after in-band delivery
// - periodic mode accepts suspend/update only
// - data-ready status bit2, read/write1 clears
module sensor_status_interrupt_regs #(
  parameter logic [6:0] TARGET_ADDR = 7'h14, // arbitrary value
  parameter bit FIRST_REVISION = 1'b0,
  parameter int WDT_SHORT_CYCLES = `WDT_SHORT_NS / `CLK_PERIOD_NS,
  parameter int WDT_LONG_CYCLES = `WDT_LONG_NS / `CLK_PERIOD_NS,
  parameter int WDT_WIDTH = 20
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic pmuBusy,
  input wire logic odrOverwritten,
  input wire logic avgOverwritten,
  input wire logic periodicModeActive,
  input wire logic [3:0] effRateCode,
  input wire logic [1:0] effAvgCode,
  input wire logic sdrParityError,
  input wire logic s0s1Error,
  input wire logic hdrExitSeen,
  input wire logic dataReadyEvent,
  input wire logic ibiDone,
  output logic ibiRequest,
  output logic cmdIssue,
  output logic [3:0] cmdIssueCode,
  output logic irqOut,
  output logic irqOe
);
  import sensor_status_pkg::*;

  localparam int S0S1_CYCLES = `S0S1_HOLD_NS / `CLK_PERIOD_NS;
  localparam int PULSE_CYCLES = (`IRQ_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  if (WDT_LONG_CYCLES >= (1 << WDT_WIDTH) || WDT_SHORT_CYCLES < 1) begin : g_chk
    $error("watchdog counts do not fit WDT_WIDTH");
  end

  // ----------------------------------------------------------------
  // reset and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rstSync;
  logic rstN;
  logic [1:0] sclSync;
  logic [1:0] sdaSync;
  logic sclD;
  logic sdaD;

  // reset release through two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstN = rstSync[1];

  // serial pins pass two flops, then an edge delay
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
      sclD <= 1'b1;
      sdaD <= 1'b1;
    end else begin
      sclSync <= {sclSync[0], sclIn};
      sdaSync <= {sdaSync[0], sdaIn};
      sclD <= sclSync[1];
      sdaD <= sdaSync[1];
    end
  end

  logic sclS;
  logic sdaS;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  assign sclS = sclSync[1];
  assign sdaS = sdaSync[1];
  assign sclRise = sclS & ~sclD;
  assign sclFall = ~sclS & sclD;
  assign startCond = sclS & sclD & sdaD & ~sdaS;
  assign stopCond = sclS & sclD & ~sdaD & sdaS;

  // ----------------------------------------------------------------
  // serial target state machine
  // ----------------------------------------------------------------
  ser_state_t state_reg;
  logic [3:0] bitCnt_reg;
  logic [7:0] rxByte_reg;
  logic [7:0] txByte_reg;
  reg_byte_t ptr_reg;
  logic firstByte_reg;
  logic readMode_reg;
  logic wrStrobe;
  logic rdStrobe;
  reg_byte_t strobeAddr;
  logic [7:0] wrData;
  reg_byte_t rdData;
  logic wdtExpire;
  reg_byte_t wdtSetup_reg;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_reg <= SER_IDLE;
      bitCnt_reg <= 4'h0;
      rxByte_reg <= 8'h00;
      txByte_reg <= 8'h00;
      ptr_reg <= 8'h00;
      firstByte_reg <= 1'b0;
      readMode_reg <= 1'b0;
      sdaOe <= 1'b0;
      sdaOut <= 1'b0;
      wrStrobe <= 1'b0;
      rdStrobe <= 1'b0;
      strobeAddr <= 8'h00;
      wrData <= 8'h00;
    end else begin
      wrStrobe <= 1'b0;
      rdStrobe <= 1'b0;
      if (stopCond || wdtExpire) begin
        state_reg <= SER_IDLE;
        sdaOe <= 1'b0;
      end else if (startCond) begin
        state_reg <= SER_ADDR;
        bitCnt_reg <= 4'h0;
        firstByte_reg <= 1'b1;
        sdaOe <= 1'b0;
      end else if (sclRise) begin
        unique case (state_reg)
          SER_ADDR, SER_WR: begin
            rxByte_reg <= {rxByte_reg[6:0], sdaS};
            bitCnt_reg <= bitCnt_reg + 4'h1;
          end
          SER_RD: bitCnt_reg <= bitCnt_reg + 4'h1;
          SER_RD_ACK: if (sdaS) state_reg <= SER_IDLE; // host nack ends read
          SER_IDLE, SER_ADDR_ACK, SER_WR_ACK: ;
        endcase
      end else if (sclFall) begin
        unique case (state_reg)
          SER_ADDR: begin
            if (bitCnt_reg == 4'h8) begin
              if (rxByte_reg[7:1] == TARGET_ADDR) begin
                state_reg <= SER_ADDR_ACK;
                readMode_reg <= rxByte_reg[0];
                sdaOe <= 1'b1;
              end else begin
                state_reg <= SER_IDLE;
              end
            end
          end
          SER_WR: begin
            if (bitCnt_reg == 4'h8) begin
              state_reg <= SER_WR_ACK;
              sdaOe <= 1'b1;
              firstByte_reg <= 1'b0;
              if (firstByte_reg) begin
                ptr_reg <= rxByte_reg; // first byte sets the pointer
              end else begin
                wrStrobe <= 1'b1;
                strobeAddr <= ptr_reg;
                wrData <= rxByte_reg;
                ptr_reg <= ptr_reg + 8'h01;
              end
            end
          end
          SER_WR_ACK: begin
            state_reg <= SER_WR;
            bitCnt_reg <= 4'h0;
            sdaOe <= 1'b0;
          end
          SER_ADDR_ACK, SER_RD_ACK: begin
            if (state_reg == SER_ADDR_ACK && !readMode_reg) begin
              state_reg <= SER_WR;
              bitCnt_reg <= 4'h0;
              sdaOe <= 1'b0;
            end else begin
              // load next byte, its read side effects fire now
              state_reg <= SER_RD;
              bitCnt_reg <= 4'h0;
              txByte_reg <= {rdData[6:0], 1'b0};
              sdaOe <= ~rdData[7];
              rdStrobe <= 1'b1;
              strobeAddr <= ptr_reg;
              ptr_reg <= ptr_reg + 8'h01;
            end
          end
          SER_RD: begin
            if (bitCnt_reg == 4'h8) begin
              state_reg <= SER_RD_ACK;
              sdaOe <= 1'b0;
            end else begin
              sdaOe <= ~txByte_reg[7];
              txByte_reg <= {txByte_reg[6:0], 1'b0};
            end
          end
          SER_IDLE: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // bus watchdog
  // ----------------------------------------------------------------
  logic [WDT_WIDTH-1:0] wdtCnt_reg;
  logic [WDT_WIDTH-1:0] wdtLimit;
  assign wdtLimit = wdtSetup_reg[`WDT_SEL] ? WDT_WIDTH'(WDT_LONG_CYCLES) :
                    WDT_WIDTH'(WDT_SHORT_CYCLES);
  assign wdtExpire = wdtSetup_reg[`WDT_EN] && (wdtCnt_reg >= wdtLimit);

  // counts while a transfer holds the clock line low
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wdtCnt_reg <= '0;
    end else if (state_reg == SER_IDLE || sclS || !wdtSetup_reg[`WDT_EN] || wdtExpire) begin
      wdtCnt_reg <= '0;
    end else begin
      wdtCnt_reg <= wdtCnt_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  reg_byte_t irqCtrl_reg;
  reg_byte_t ibiCtrl_reg;

  // writable bits only, reserved bits stay zero
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wdtSetup_reg <= `REG_RESET;
      irqCtrl_reg <= `REG_RESET;
      ibiCtrl_reg <= `REG_RESET;
    end else if (wrStrobe) begin
      if (strobeAddr == `REG_WDT) wdtSetup_reg <= wrData & `WDT_MASK;
      if (strobeAddr == `REG_IRQ_CTRL) irqCtrl_reg <= wrData & `IRQ_CTRL_MASK;
      if (strobeAddr == `REG_IBI_CTRL) ibiCtrl_reg <= wrData & `IBI_MASK;
    end
  end

  // ----------------------------------------------------------------
  // command filter and power status
  // ----------------------------------------------------------------
  reg_byte_t pwrStatus_reg;
  reg_byte_t effRate_reg;
  logic cmdWrite;
  logic cmdLegal;
  assign cmdWrite = wrStrobe && strobeAddr == `REG_PMU_CMD;
  assign cmdLegal = (wrData[3:0] <= `CMD_MAX) && (wrData[7:4] == 4'h0) &&
                    (!periodicModeActive || wrData[3:0] == `CMD_SUSPEND ||
                     wrData[3:0] == `CMD_UPDATE);

  // forwards only permitted commands
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cmdIssue <= 1'b0;
      cmdIssueCode <= 4'h0;
    end else begin
      cmdIssue <= cmdWrite && cmdLegal;
      if (cmdWrite && cmdLegal) cmdIssueCode <= wrData[3:0];
    end
  end

  // status flags mirror the power controller; busy also rises on an issued command, and the command filter sets the reject flag
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pwrStatus_reg <= `REG_RESET;
      effRate_reg <= `REG_RESET;
    end else begin
      pwrStatus_reg[`ST_BUSY] <= pmuBusy | cmdIssue;
      pwrStatus_reg[`ST_ODR_OVW] <= odrOverwritten;
      pwrStatus_reg[`ST_AVG_OVW] <= avgOverwritten;
      pwrStatus_reg[`ST_PERIODIC] <= periodicModeActive;
      if (cmdWrite) pwrStatus_reg[`ST_REJECT] <= ~cmdLegal;
      effRate_reg <= 8'(effRateCode) | (8'(effAvgCode) << `AVG_LSB);
    end
  end

  // ----------------------------------------------------------------
  // bus error flags
  // ----------------------------------------------------------------
  reg_byte_t busErr_reg;
  logic [10:0] s0s1Cnt_reg;
  logic errRdClr;
  logic [7:0] errWrClr;
  assign errRdClr = rdStrobe && strobeAddr == `REG_BUS_ERR;
  assign errWrClr = (wrStrobe && strobeAddr == `REG_BUS_ERR) ? wrData : 8'h00;

  // set wins over any clear in the same cycle
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      busErr_reg <= `REG_RESET;
      s0s1Cnt_reg <= 11'h000;
    end else begin
      if (sdrParityError) begin
        busErr_reg[`ERR_PARITY] <= 1'b1;
      end else if (errRdClr || errWrClr[`ERR_PARITY]) begin
        busErr_reg[`ERR_PARITY] <= 1'b0;
      end
      if (s0s1Error) begin
        busErr_reg[`ERR_S0S1] <= 1'b1;
        s0s1Cnt_reg <= 11'h000;
      end else if (errRdClr || errWrClr[`ERR_S0S1] || hdrExitSeen ||
                   s0s1Cnt_reg == 11'(S0S1_CYCLES - 1)) begin
        busErr_reg[`ERR_S0S1] <= 1'b0;
        s0s1Cnt_reg <= 11'h000;
      end else if (busErr_reg[`ERR_S0S1]) begin
        s0s1Cnt_reg <= s0s1Cnt_reg + 11'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // data-ready status, in-band request and interrupt pin
  // ----------------------------------------------------------------
  logic drdyStatus_reg;
  logic [5:0] pulseCnt_reg;
  logic drdySet;
  logic drdyClr;
  logic irqActive;
  logic pinRouted;
  assign drdySet = dataReadyEvent && irqCtrl_reg[`IRQ_DRDY_EN];
  assign drdyClr = (rdStrobe && strobeAddr == `REG_INT_STATUS) ||
                   (wrStrobe && strobeAddr == `REG_INT_STATUS && wrData[`DRDY_BIT]) ||
                   (ibiDone && ibiCtrl_reg[`IBI_AUTOCLR]);
  assign pinRouted = FIRST_REVISION || irqCtrl_reg[`IRQ_OEN];
  assign irqActive = pinRouted && (irqCtrl_reg[`IRQ_MODE] ? drdyStatus_reg :
                     (pulseCnt_reg != 6'h00));

  // sticky data-ready flag, set wins
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      drdyStatus_reg <= 1'b0;
    end else if (drdySet) begin
      drdyStatus_reg <= 1'b1;
    end else if (drdyClr) begin
      drdyStatus_reg <= 1'b0;
    end
  end

  // fixed-length pulse per event
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pulseCnt_reg <= 6'h00;
    end else if (drdySet) begin
      pulseCnt_reg <= 6'(PULSE_CYCLES);
    end else if (pulseCnt_reg != 6'h00) begin
      pulseCnt_reg <= pulseCnt_reg - 6'h01;
    end
  end

  // in-band request held until delivered
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      ibiRequest <= 1'b0;
    end else if (dataReadyEvent && ibiCtrl_reg[`IBI_MAP]) begin
      ibiRequest <= 1'b1;
    end else if (ibiDone) begin
      ibiRequest <= 1'b0;
    end
  end

  // pin level and drive
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      irqOut <= 1'b0;
      irqOe <= 1'b0;
    end else begin
      irqOut <= irqActive ~^ irqCtrl_reg[`IRQ_POL];
      irqOe <= irqCtrl_reg[`IRQ_DRV] | ~(irqActive ~^ irqCtrl_reg[`IRQ_POL]);
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_comb begin
    unique case (ptr_reg)
      `REG_PWR_STATUS: rdData = pwrStatus_reg;
      `REG_EFF_RATE: rdData = effRate_reg;
      `REG_BUS_ERR: rdData = busErr_reg & `ERR_MASK;
      `REG_WDT: rdData = wdtSetup_reg;
      `REG_IRQ_CTRL: rdData = irqCtrl_reg;
      `REG_IBI_CTRL: rdData = ibiCtrl_reg;
      `REG_INT_STATUS: rdData = 8'(drdyStatus_reg) << `DRDY_BIT;
      default: rdData = 8'h00; // unmapped reads as zero
    endcase
  end
endmodule
`default_nettype wire

/* File: rtl/sensor_status_params.svh */
// constants for the sensor status and interrupt register bank
`ifndef SENSOR_STATUS_PARAMS_SVH
`define SENSOR_STATUS_PARAMS_SVH
// register offsets
`define REG_PMU_CMD 8'h06
`define REG_PWR_STATUS 8'h07
`define REG_EFF_RATE 8'h08
`define REG_BUS_ERR 8'h09
`define REG_WDT 8'h0A
`define REG_IRQ_CTRL 8'h2E
`define REG_IBI_CTRL 8'h2F
`define REG_INT_STATUS 8'h30
// field positions
`define ST_BUSY 0
`define ST_ODR_OVW 1
`define ST_AVG_OVW 2
`define ST_PERIODIC 3
`define ST_REJECT 4
`define ERR_PARITY 0
`define ERR_S0S1 3
`define WDT_EN 0
`define WDT_SEL 1
`define IRQ_MODE 0
`define IRQ_POL 1
`define IRQ_DRV 2
`define IRQ_OEN 3
`define IRQ_DRDY_EN 7
`define IBI_MAP 0
`define IBI_AUTOCLR 4
`define DRDY_BIT 2
`define AVG_LSB 4
// writable masks, error read mask and reset value
`define WDT_MASK 8'h03
`define IRQ_CTRL_MASK 8'h8F
`define IBI_MASK 8'h11
`define ERR_MASK 8'h09
`define REG_RESET 8'h00
// command codes
`define CMD_SUSPEND 4'h0
`define CMD_UPDATE 4'h2
`define CMD_MAX 4'h8
// timing, in nanoseconds
`define CLK_PERIOD_NS 50
`define S0S1_HOLD_NS 60000
`define WDT_SHORT_NS 1280000
`define WDT_LONG_NS 40960000
`define IRQ_PULSE_NS 2500
`endif

/* File: rtl/sensor_status_pkg.sv */
// types shared by the sensor status register bank
`default_nettype none
package sensor_status_pkg;
  typedef enum logic [6:0] {
    SER_IDLE = 7'h01,
    SER_ADDR = 7'h02,
    SER_ADDR_ACK = 7'h04,
    SER_WR = 7'h08,
    SER_WR_ACK = 7'h10,
    SER_RD = 7'h20,
    SER_RD_ACK = 7'h40
  } ser_state_t;
  typedef logic [7:0] reg_byte_t;
endpackage
`default_nettype wire

/* File: tb/sensor_status_assertions.sv */
// port-level checks for the sensor status register bank
`default_nettype none
`include "sensor_status_params.svh"
module sensor_status_assertions (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sclIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic periodicModeActive,
  input wire logic dataReadyEvent,
  input wire logic ibiDone,
  input wire logic ibiRequest,
  input wire logic cmdIssue,
  input wire logic [3:0] cmdIssueCode,
  input wire logic irqOut,
  input wire logic irqOe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  logic [7:0] irqAge;
  logic [1:0] prevPair;
  // -----------------------------------------------
  // cycles since the interrupt pin last changed
  // -----------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irqAge <= 8'hFF;
      prevPair <= 2'h0;
    end else begin
      prevPair <= {irqOut, irqOe};
      if ({irqOut, irqOe} != prevPair) irqAge <= 8'h00;
      else if (irqAge != 8'hFF) irqAge <= irqAge + 8'h01;
    end
  end
  sda_open_drain_a: assert property (sdaOut == 1'b0)
    else $error("data pin driven high");
  ack_timing_a: assert property ($changed(sdaOe) |-> !$past(sclIn, 3))
    else $error("data drive changed outside clock low");
  cmd_pulse_a: assert property (cmdIssue |=> !cmdIssue)
    else $error("command pulse longer than one cycle");
  cmd_hold_a: assert property ($changed(cmdIssueCode) |-> cmdIssue)
    else $error("command code changed without issue");
  cmd_legal_a: assert property (cmdIssue |-> cmdIssueCode <= `CMD_MAX)
    else $error("illegal command passed on");
  cmd_mode_a: assert property (cmdIssue && periodicModeActive |->
    cmdIssueCode inside {`CMD_SUSPEND, `CMD_UPDATE})
    else $error("blocked command passed in periodic mode");
  ibi_clear_a: assert property (ibiDone && !dataReadyEvent |=> !ibiRequest)
    else $error("in-band request not dropped");
  ibi_cause_a: assert property ($rose(ibiRequest) |->
    $past(dataReadyEvent) || $past(dataReadyEvent, 2))
    else $error("in-band request without data ready");
  pulse_len_a: assert property ($changed({irqOut, irqOe}) &&
    !$past(dataReadyEvent, 2) |-> irqAge >= 8'h31)
    else $error("interrupt pulse too short");
  cover property (cmdIssue);
  cover property ($rose(ibiRequest));
  cover property ($changed({irqOut, irqOe}));
endmodule
`default_nettype wire

/* File: tb/i2c_host_model.sv */
// serial host driving the link and collecting read bytes
`default_nettype none
module i2c_host_model #(
  parameter logic [6:0] ADDR = 7'h14
) (
  input wire logic clk,
  input wire logic sdaWire,
  output logic sclDrv,
  output logic sdaRel,
  output logic rdValid,
  output logic [7:0] rdData
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ackSeen;
  // ---------------------------------
  // link idles high, clock stands still
  // ---------------------------------
  initial begin
    sclDrv = 1'b1;
    sdaRel = 1'b1;
    rdValid = 1'b0;
    rdData = 8'h00;
  end
  // quarter link period, two system clocks
  task automatic q();
    repeat (2) @(posedge clk);
  endtask
  // data changes mid-low, sampled mid-high
  task automatic bitx(input logic b, output logic s);
    q();
    sdaRel <= b;
    q();
    sclDrv <= 1'b1;
    q();
    s = sdaWire;
    q();
    sclDrv <= 1'b0;
  endtask
  task automatic byteOut(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(d[i], s);
    bitx(1'b1, ackSeen);
  endtask
  task automatic byteIn(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(last, ackSeen);
  endtask
  // start or repeated start
  task automatic start();
    q();
    sdaRel <= 1'b1;
    q();
    sclDrv <= 1'b1;
    q();
    sdaRel <= 1'b0;
    q();
    sclDrv <= 1'b0;
  endtask
  task automatic stop();
    q();
    sdaRel <= 1'b0;
    q();
    sclDrv <= 1'b1;
    q();
    sdaRel <= 1'b1;
    q();
  endtask
  task automatic writeReg(input logic [7:0] a, input logic [7:0] d);
    start();
    byteOut({ADDR, 1'b0});
    byteOut(a);
    byteOut(d);
    stop();
  endtask
  // pointer write, repeated start, one byte with nack
  task automatic readReg(input logic [7:0] a);
    logic [7:0] d;
    start();
    byteOut({ADDR, 1'b0});
    byteOut(a);
    start();
    byteOut({ADDR, 1'b1});
    byteIn(1'b1, d);
    stop();
    rdData <= d;
    rdValid <= 1'b1;
    @(posedge clk);
    rdValid <= 1'b0;
  endtask
  // address byte, then the clock is parked low while the ack is due
  task automatic stall(input int n, output logic s);
    logic b;
    logic [7:0] a = {ADDR, 1'b0};
    start();
    for (int i = 7; i >= 0; i--) bitx(a[i], b);
    q();
    sdaRel <= 1'b1;
    repeat (n) @(posedge clk);
    s = sdaWire;
    bitx(1'b1, ackSeen);
    stop();
  endtask
endmodule
`default_nettype wire

/* File: tb/sensor_status_interrupt_regs_test.sv */
// top-level bench for the sensor status register bank
`default_nettype none
`include "sensor_status_params.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %h want %h", $time, (g), (e)); end end
module sensor_status_interrupt_regs_test;
  import sensor_status_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, arst_n, sclDrv, sdaRel, sdaOut, sdaOe, rdValid, sdaWire;
  logic pmuBusy, odrOv, avgOv, periodic, ibiRequest, cmdIssue, irqOut, irqOe;
  logic [4:0] pls;
  logic [3:0] rateCode, cmdIssueCode;
  logic [1:0] avgCode;
  reg_byte_t rdData;
  reg_byte_t expRd[$];
  logic [3:0] expCmd[$];
  reg_byte_t regs[7] = '{8'h07, 8'h08, 8'h09, 8'h0A, 8'h2E, 8'h2F, 8'h30};
  reg_byte_t wdtCfg[3] = '{8'h01, 8'h03, 8'h00};
  logic wdtSeen;
  int n_errors = 0;
  int compares = 0;
  logic [31:0] rng = 32'hCC7A;
  assign sdaWire = sdaRel & ~(sdaOe & ~sdaOut);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  sensor_status_interrupt_regs #(.WDT_SHORT_CYCLES(40), .WDT_LONG_CYCLES(80)) dut_u (
    .clk(clk), .arst_n(arst_n), .sclIn(sclDrv), .sdaIn(sdaWire), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .pmuBusy(pmuBusy), .odrOverwritten(odrOv), .avgOverwritten(avgOv),
    .periodicModeActive(periodic), .effRateCode(rateCode), .effAvgCode(avgCode),
    .sdrParityError(pls[0]), .s0s1Error(pls[1]), .hdrExitSeen(pls[2]),
    .dataReadyEvent(pls[3]), .ibiDone(pls[4]), .ibiRequest(ibiRequest),
    .cmdIssue(cmdIssue), .cmdIssueCode(cmdIssueCode), .irqOut(irqOut), .irqOe(irqOe));
  i2c_host_model #(.ADDR(7'h14)) host_u (.clk(clk), .sdaWire(sdaWire), .sclDrv(sclDrv),
    .sdaRel(sdaRel), .rdValid(rdValid), .rdData(rdData));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic end_of_test();
    if (n_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic rd(input reg_byte_t a, input reg_byte_t e);
    expRd.push_back(e);
    host_u.readReg(a);
  endtask
  task automatic wr(input reg_byte_t a, input reg_byte_t d);
    host_u.writeReg(a, d);
  endtask
  // one-cycle pulse: 0 parity, 1 bus error, 2 exit, 3 data ready, 4 delivered
  task automatic pulse(input int k);
    @(posedge clk);
    pls[k] <= 1'b1;
    @(posedge clk);
    pls <= 5'h00;
  endtask
  // pin after a data-ready event: active cycles 2..51, then idle
  task automatic drdyPin(input logic [1:0] act, input logic [1:0] idle);
    pulse(3);
    repeat (2) @(posedge clk);
    #1 `CHK({irqOut, irqOe}, act)
    repeat (48) @(posedge clk);
    #1 `CHK({irqOut, irqOe}, act)
    @(posedge clk);
    #1 `CHK({irqOut, irqOe}, idle)
  endtask
  // ---------------------------------
  // result watcher: oldest note first
  // ---------------------------------
  always @(posedge clk) begin
    reg_byte_t e;
    if (rdValid === 1'b1) begin
      e = (expRd.size() > 0) ? expRd.pop_front() : 8'hXX;
      `CHK(rdData, e)
    end
    if (cmdIssue === 1'b1) begin
      e = (expCmd.size() > 0) ? {4'h0, expCmd.pop_front()} : 8'hXX;
      `CHK({4'h0, cmdIssueCode}, e)
    end
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
  // ---------------------------------
  // main sequence
  // ---------------------------------
  initial begin
    arst_n = 1'b0;
    {pmuBusy, odrOv, avgOv, periodic, rateCode, avgCode} = 10'h000;
    pls = 5'h00;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    #1 `CHK({irqOut, irqOe}, 2'b10)
    foreach (regs[i]) rd(regs[i], `REG_RESET);
    rd(8'h20, 8'h00);
    repeat (4) begin
      rng = xs(rng);
      @(posedge clk);
      {pmuBusy, odrOv, avgOv, periodic, rateCode, avgCode} <= rng[9:0];
      rd(`REG_PWR_STATUS, {4'h0, rng[6], rng[7], rng[8], rng[9]});
      rd(`REG_EFF_RATE, {2'h0, rng[1:0], rng[5:2]});
      wr(`REG_WDT, rng[17:10]);
      rd(`REG_WDT, rng[17:10] & `WDT_MASK);
      wr(`REG_IRQ_CTRL, rng[25:18]);
      rd(`REG_IRQ_CTRL, rng[25:18] & `IRQ_CTRL_MASK);
      wr(`REG_IBI_CTRL, rng[31:24]);
      rd(`REG_IBI_CTRL, rng[31:24] & `IBI_MASK);
    end
    {pmuBusy, odrOv, avgOv, periodic} <= 4'h0; // all codes up to 8 legal while periodic is low
    pulse(0);
    pulse(1);
    rd(`REG_BUS_ERR, 8'h09);
    rd(`REG_BUS_ERR, 8'h00);
    pulse(0);
    pulse(1);
    wr(`REG_BUS_ERR, 8'h01);
    rd(`REG_BUS_ERR, 8'h08);
    pulse(1);
    repeat (800) @(posedge clk);
    rd(`REG_BUS_ERR, 8'h08);
    pulse(1);
    repeat (1210) @(posedge clk);
    rd(`REG_BUS_ERR, 8'h00);
    pulse(1);
    pulse(2);
    rd(`REG_BUS_ERR, 8'h00);
    wr(`REG_PMU_CMD, 8'h09);
    rd(`REG_PWR_STATUS, 8'h10);
    wr(`REG_PMU_CMD, 8'h12);
    rd(`REG_PWR_STATUS, 8'h10);
    for (int c = 1; c <= 8; c++) begin
      expCmd.push_back(c[3:0]);
      wr(`REG_PMU_CMD, c[7:0]);
    end
    rd(`REG_PWR_STATUS, 8'h00);
    periodic <= 1'b1;
    wr(`REG_PMU_CMD, 8'h03);
    rd(`REG_PWR_STATUS, 8'h18);
    pulse(3); // data ready since the earlier update
    expCmd.push_back(`CMD_UPDATE);
    wr(`REG_PMU_CMD, {4'h0, `CMD_UPDATE});
    expCmd.push_back(`CMD_SUSPEND);
    wr(`REG_PMU_CMD, {4'h0, `CMD_SUSPEND});
    rd(`REG_PWR_STATUS, 8'h08);
    periodic <= 1'b0;
    // parked clock: only the short enabled watchdog frees the data line
    foreach (wdtCfg[i]) begin
      wr(`REG_WDT, wdtCfg[i]);
      host_u.stall(60, wdtSeen);
      `CHK(wdtSeen, wdtCfg[i] == 8'h01)
    end
    wr(`REG_IBI_CTRL, 8'h00);
    wr(`REG_IRQ_CTRL, 8'h88);
    drdyPin(2'b01, 2'b10);
    rd(`REG_INT_STATUS, 8'h04);
    rd(`REG_INT_STATUS, 8'h00);
    wr(`REG_IRQ_CTRL, 8'h8F);
    drdyPin(2'b11, 2'b11);
    rd(`REG_INT_STATUS, 8'h04);
    @(posedge clk);
    #1 `CHK({irqOut, irqOe}, 2'b01)
    drdyPin(2'b11, 2'b11);
    wr(`REG_INT_STATUS, 8'h04);
    #1 `CHK({irqOut, irqOe}, 2'b01)
    wr(`REG_IRQ_CTRL, 8'h0F);
    drdyPin(2'b01, 2'b01);
    rd(`REG_INT_STATUS, 8'h00);
    wr(`REG_IRQ_CTRL, 8'h87);
    drdyPin(2'b01, 2'b01);
    rd(`REG_INT_STATUS, 8'h04);
    wr(`REG_IBI_CTRL, 8'h01);
    for (int m = 0; m < 2; m++) begin
      pulse(3);
      for (int i = 0; i < 10 && ibiRequest !== 1'b1; i++) @(posedge clk);
      `CHK(ibiRequest, 1'b1)
      if (ibiRequest !== 1'b1) end_of_test();
      pulse(4);
      #1 `CHK(ibiRequest, 1'b0)
      rd(`REG_INT_STATUS, (m == 0) ? 8'h04 : 8'h00);
      wr(`REG_IBI_CTRL, 8'h11);
    end
    wr(`REG_IBI_CTRL, 8'h00);
    pulse(3);
    repeat (5) @(posedge clk);
    #1 `CHK(ibiRequest, 1'b0)
    rd(`REG_INT_STATUS, 8'h04);
    repeat (10) @(posedge clk);
    `CHK(expCmd.size() + expRd.size(), 0)
    end_of_test();
  end
endmodule
bind sensor_status_interrupt_regs sensor_status_assertions chk_u (.clk(clk), .arst_n(arst_n),
  .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .periodicModeActive(periodicModeActive),
  .dataReadyEvent(dataReadyEvent), .ibiDone(ibiDone), .ibiRequest(ibiRequest),
  .cmdIssue(cmdIssue), .cmdIssueCode(cmdIssueCode), .irqOut(irqOut), .irqOe(irqOe));
`default_nettype wire
